// >>> pkg/ffc_pkg.sv
// ffc_pkg: constants and types for the parallel flash command controller.
// assumes a 50 MHz controller clock and a byte-wide flash with active-low strobes.
package ffc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// widths
	localparam int ADDR_W = 18;
	localparam int DATA_W = 8;
	localparam int IDX_W = 3;
	localparam int CNT_W = 8;
	localparam int WIN_W = 11;

	////////////////////////////////////////////////////////////////////////////////
	// command codes
	localparam logic [7:0] CMD_PROGRAM = 8'hA0;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;

	// unlock, reset and identifier cycles: plain defaults, to be set per part
	localparam logic [17:0] DEF_UNLOCK1_ADDR = 18'h00001;
	localparam logic [7:0] DEF_UNLOCK1_DATA = 8'h01;
	localparam logic [17:0] DEF_UNLOCK2_ADDR = 18'h00002;
	localparam logic [7:0] DEF_UNLOCK2_DATA = 8'h02;
	localparam logic [17:0] DEF_RESET_ADDR = 18'h00000;
	localparam logic [7:0] DEF_RESET_DATA = 8'h03;
	localparam logic [7:0] DEF_ID_DATA = 8'h04;

	////////////////////////////////////////////////////////////////////////////////
	// status bit positions
	localparam int BIT_POLL = 7;
	localparam int BIT_TOGGLE = 6;
	localparam int BIT_TIMEOUT = 5;
	localparam int BIT_ERASE_TIMER = 3;

	////////////////////////////////////////////////////////////////////////////////
	// sequence steps
	localparam logic [2:0] SEQ_IDX_U1 = 3'h0;
	localparam logic [2:0] SEQ_IDX_U2 = 3'h1;
	localparam logic [2:0] SEQ_IDX_CMD = 3'h2;
	localparam logic [2:0] SEQ_IDX_PGM_DATA = 3'h3;
	localparam logic [2:0] SEQ_IDX_U2B = 3'h4;
	localparam logic [2:0] SEQ_IDX_SECTOR = 3'h5;
	localparam logic [2:0] SEQ_LAST_SINGLE = 3'h0;
	localparam logic [2:0] SEQ_LAST_ID = 3'h2;
	localparam logic [2:0] SEQ_LAST_PROGRAM = 3'h3;
	localparam logic [2:0] SEQ_LAST_ERASE = 3'h5;

	////////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int T_SETUP_NS = 20;
	localparam int T_STROBE_NS = 60;
	localparam int T_HOLD_NS = 20;
	localparam int ERASE_WINDOW_US = 30;
	localparam int CYC_SETUP_I = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_STROBE_I = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_HOLD_I = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] CYC_SETUP = CNT_W'(CYC_SETUP_I < 1 ? 1 : CYC_SETUP_I);
	localparam logic [7:0] CYC_STROBE = CNT_W'(CYC_STROBE_I < 1 ? 1 : CYC_STROBE_I);
	localparam logic [7:0] CYC_HOLD = CNT_W'(CYC_HOLD_I < 1 ? 1 : CYC_HOLD_I);
	// longest window rounds down
	localparam logic [10:0] CYC_ERASE_WINDOW = WIN_W'((ERASE_WINDOW_US * 1000) / CLK_PERIOD_NS);
	localparam logic [7:0] CNT_ONE = 8'h01;
	localparam logic [10:0] WIN_ONE = 11'h001;

	////////////////////////////////////////////////////////////////////////////////
	// user operations
	typedef enum logic [2:0] {
		OP_READ,
		OP_PROGRAM,
		OP_ERASE,
		OP_ADD_SECTOR,
		OP_POLL,
		OP_RESET,
		OP_ID
	} ffc_op_t;

endpackage

// >>> hdl/ffc_bus_cycle.sv
// ffc_bus_cycle: one read or write cycle on the flash pins.
// assumes the flash answers reads within the strobe time.
`timescale 1ns/1ps

module ffc_bus_cycle import ffc_pkg::*; #(
	parameter int AW = ADDR_W,
	parameter int DW = DATA_W
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_start,
	input wire logic i_write,
	input wire logic [AW-1:0] i_addr,
	input wire logic [DW-1:0] i_wdata,
	output logic o_done,
	output logic [DW-1:0] o_rdata,
	output logic o_ce_n,
	output logic o_oe_n,
	output logic o_we_n,
	output logic [AW-1:0] o_addr,
	output logic [DW-1:0] o_dq_o,
	output logic o_dq_oe,
	input wire logic [DW-1:0] i_dq_i
);

	typedef enum logic [1:0] {
		BC_IDLE,
		BC_SETUP,
		BC_STROBE,
		BC_HOLD
	} ffc_bc_state_t;

	typedef struct packed {
		ffc_bc_state_t state;
		logic [CNT_W-1:0] cnt;
		logic write;
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
		logic [DW-1:0] rdata;
		logic done;
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic dq_oe;
	} ffc_bc_t;

	ffc_bc_t st_r;
	ffc_bc_t st_nxt;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		st_nxt.cnt = st_r.cnt + CNT_ONE;
		case (st_r.state)
			BC_IDLE: begin
				st_nxt.cnt = '0;
				if (i_start) begin
					st_nxt.state = BC_SETUP;
					st_nxt.write = i_write;
					st_nxt.addr = i_addr;
					st_nxt.wdata = i_wdata;
					st_nxt.ce_n = 1'b0;
					st_nxt.dq_oe = i_write;
				end
			end
			BC_SETUP: begin
				if (st_r.cnt == CYC_SETUP - CNT_ONE) begin
					st_nxt.cnt = '0;
					st_nxt.state = BC_STROBE;
					// write only with output gate high, read only with write strobe high
					st_nxt.we_n = ~st_r.write;
					st_nxt.oe_n = st_r.write;
				end
			end
			BC_STROBE: begin
				if (st_r.cnt == CYC_STROBE - CNT_ONE) begin
					st_nxt.cnt = '0;
					st_nxt.state = BC_HOLD;
					// address held from falling edge, data until rising edge
					st_nxt.we_n = 1'b1;
					st_nxt.oe_n = 1'b1;
					if (!st_r.write) begin
						st_nxt.rdata = i_dq_i;
					end
				end
			end
			BC_HOLD: begin
				if (st_r.cnt == CYC_HOLD - CNT_ONE) begin
					st_nxt.cnt = '0;
					st_nxt.state = BC_IDLE;
					st_nxt.ce_n = 1'b1;
					st_nxt.dq_oe = 1'b0;
					st_nxt.done = 1'b1;
				end
			end
			default: begin
				st_nxt.state = BC_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			st_r <= '{state: BC_IDLE, cnt: '0, write: 1'b0, addr: '0, wdata: '0, rdata: '0,
				done: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_done = st_r.done;
	assign o_rdata = st_r.rdata;
	assign o_ce_n = st_r.ce_n;
	assign o_oe_n = st_r.oe_n;
	assign o_we_n = st_r.we_n;
	assign o_addr = st_r.addr;
	assign o_dq_o = st_r.wdata;
	assign o_dq_oe = st_r.dq_oe;

endmodule // ffc_bus_cycle

// >>> hdl/ffc_ctrl.sv
// ffc_ctrl: host-side controller for a byte-wide flash with command sequences and status polling.
// assumes one user command at a time; the flash pins are wired straight to the device.
`timescale 1ns/1ps

// Behaviour
// - program starts with two unlock writes then the program command code.
// - read twice, compare toggle; on timeout recheck; still toggling means fail, reset.
// - reset must follow a timeout before any new program or erase.
// - erase timer bit checked before and after each added sector command.
// - write only with chip-select and write strobe low, output gate high.
// - each added sector write must start within the window after the last.
// - sector erase takes six writes: unlocks, set-up, unlocks, sector code.
module ffc_ctrl import ffc_pkg::*; #(
	parameter int AW = ADDR_W,
	parameter int DW = DATA_W,
	parameter logic [ADDR_W-1:0] UNLOCK1_ADDR = DEF_UNLOCK1_ADDR,
	parameter logic [DATA_W-1:0] UNLOCK1_DATA = DEF_UNLOCK1_DATA,
	parameter logic [ADDR_W-1:0] UNLOCK2_ADDR = DEF_UNLOCK2_ADDR,
	parameter logic [DATA_W-1:0] UNLOCK2_DATA = DEF_UNLOCK2_DATA,
	parameter logic [ADDR_W-1:0] RESET_ADDR = DEF_RESET_ADDR,
	parameter logic [DATA_W-1:0] RESET_DATA = DEF_RESET_DATA,
	parameter logic [DATA_W-1:0] ID_DATA = DEF_ID_DATA
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_cmd_valid,
	input wire ffc_op_t i_cmd_op,
	input wire logic [AW-1:0] i_cmd_addr,
	input wire logic [DW-1:0] i_cmd_data,
	output logic o_cmd_ready,
	output logic o_done,
	output logic o_fail,
	output logic [DW-1:0] o_rdata,
	output logic o_erase_window_open,
	output logic o_flash_ce_n,
	output logic o_flash_oe_n,
	output logic o_flash_we_n,
	output logic [AW-1:0] o_flash_addr,
	output logic [DW-1:0] o_flash_dq_o,
	output logic o_flash_dq_oe,
	input wire logic [DW-1:0] i_flash_dq_i
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_TIMER_PRE,
		ST_WRITE,
		ST_TIMER_POST,
		ST_READ,
		ST_POLL_A,
		ST_POLL_B
	} ffc_state_t;

	typedef struct packed {
		ffc_state_t state;
		ffc_op_t op;
		logic [IDX_W-1:0] idx;
		logic [AW-1:0] addr;
		logic [DW-1:0] data;
		logic wait_bus;
		logic tog_first;
		logic tmo_seen;
		logic fail;
		logic done;
		logic [DW-1:0] rdata;
		logic [WIN_W-1:0] win_cnt;
		logic win_open;
	} ffc_ctrl_t;

	ffc_ctrl_t st_r;
	ffc_ctrl_t st_nxt;

	logic bus_start;
	logic bus_write;
	logic [AW-1:0] bus_addr;
	logic [DW-1:0] bus_wdata;
	logic bus_done;
	logic [DW-1:0] bus_rdata;
	logic [AW+DW-1:0] word;
	logic [IDX_W-1:0] last_idx;

	////////////////////////////////////////////////////////////////////////////////
	// address and data of one step of a command sequence
	function automatic logic [AW+DW-1:0] seq_word(input ffc_op_t op, input logic [IDX_W-1:0] idx,
		input logic [AW-1:0] a, input logic [DW-1:0] d);
		logic [AW-1:0] wa;
		logic [DW-1:0] wd;
		wa = UNLOCK1_ADDR;
		wd = UNLOCK1_DATA;
		if (op == OP_ADD_SECTOR) begin
			wa = a;
			wd = CMD_SECTOR_ERASE;
		end else if (op == OP_RESET) begin
			wa = RESET_ADDR;
			wd = RESET_DATA;
		end else if (idx == SEQ_IDX_U2 || idx == SEQ_IDX_U2B) begin
			wa = UNLOCK2_ADDR;
			wd = UNLOCK2_DATA;
		end else if (idx == SEQ_IDX_CMD) begin
			if (op == OP_PROGRAM) begin
				wd = CMD_PROGRAM;
			end else if (op == OP_ERASE) begin
				wd = CMD_ERASE_SETUP;
			end else begin
				wd = ID_DATA;
			end
		end else if (idx == SEQ_IDX_PGM_DATA && op == OP_PROGRAM) begin
			wa = a;
			wd = d;
		end else if (idx == SEQ_IDX_SECTOR) begin
			wa = a;
			wd = CMD_SECTOR_ERASE;
		end
		return {wa, wd};
	endfunction

	function automatic logic [IDX_W-1:0] seq_last(input ffc_op_t op);
		logic [IDX_W-1:0] n;
		n = SEQ_LAST_SINGLE;
		case (op)
			OP_PROGRAM: n = SEQ_LAST_PROGRAM;
			OP_ERASE: n = SEQ_LAST_ERASE;
			OP_ID: n = SEQ_LAST_ID;
			default: n = SEQ_LAST_SINGLE;
		endcase
		return n;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		bus_start = 1'b0;
		bus_write = 1'b0;
		bus_addr = st_r.addr;
		bus_wdata = st_r.data;
		word = seq_word(st_r.op, st_r.idx, st_r.addr, st_r.data);
		last_idx = seq_last(st_r.op);
		// time since the last sector-load strobe rose
		if (st_r.win_open) begin
			if (st_r.win_cnt == CYC_ERASE_WINDOW - WIN_ONE) begin
				st_nxt.win_open = 1'b0;
			end else begin
				st_nxt.win_cnt = st_r.win_cnt + WIN_ONE;
			end
		end
		// issue one bus cycle per state visit, and one per sequence step in ST_WRITE
		if (st_r.state != ST_IDLE && !st_r.wait_bus) begin
			bus_start = 1'b1;
			st_nxt.wait_bus = 1'b1;
		end
		if (st_r.state == ST_WRITE) begin
			bus_write = 1'b1;
			bus_addr = word[AW+DW-1:DW];
			bus_wdata = word[DW-1:0];
		end
		case (st_r.state)
			ST_IDLE: begin
				if (i_cmd_valid) begin
					st_nxt.op = i_cmd_op;
					st_nxt.addr = i_cmd_addr;
					st_nxt.data = i_cmd_data;
					st_nxt.idx = '0;
					st_nxt.fail = 1'b0;
					st_nxt.tmo_seen = 1'b0;
					case (i_cmd_op)
						OP_READ: st_nxt.state = ST_READ;
						OP_POLL: st_nxt.state = ST_POLL_A;
						OP_ADD_SECTOR: st_nxt.state = ST_TIMER_PRE;
						default: st_nxt.state = ST_WRITE;
					endcase
				end
			end
			ST_TIMER_PRE: begin
				if (bus_done) begin
					st_nxt.wait_bus = 1'b0;
					if (bus_rdata[BIT_ERASE_TIMER] || !st_r.win_open) begin
						st_nxt.fail = 1'b1;
						st_nxt.done = 1'b1;
						st_nxt.rdata = bus_rdata;
						st_nxt.state = ST_IDLE;
					end else begin
						st_nxt.state = ST_WRITE;
					end
				end
			end
			ST_WRITE: begin
				if (bus_done) begin
					st_nxt.wait_bus = 1'b0;
					st_nxt.idx = st_r.idx + 3'h1;
					if (st_r.idx == last_idx) begin
						st_nxt.idx = '0;
						case (st_r.op)
							OP_PROGRAM: st_nxt.state = ST_POLL_A;
							OP_ADD_SECTOR: begin
								st_nxt.win_open = 1'b1;
								st_nxt.win_cnt = '0;
								st_nxt.state = ST_TIMER_POST;
							end
							OP_ERASE: begin
								st_nxt.win_open = 1'b1;
								st_nxt.win_cnt = '0;
								st_nxt.done = 1'b1;
								st_nxt.state = ST_IDLE;
							end
							OP_ID: st_nxt.state = ST_READ;
							default: begin
								st_nxt.win_open = 1'b0;
								st_nxt.done = 1'b1;
								st_nxt.state = ST_IDLE;
							end
						endcase
					end
				end
			end
			ST_TIMER_POST: begin
				if (bus_done) begin
					st_nxt.wait_bus = 1'b0;
					st_nxt.fail = bus_rdata[BIT_ERASE_TIMER];
					st_nxt.rdata = bus_rdata;
					st_nxt.done = 1'b1;
					st_nxt.state = ST_IDLE;
				end
			end
			ST_READ: begin
				if (bus_done) begin
					st_nxt.wait_bus = 1'b0;
					st_nxt.rdata = bus_rdata;
					st_nxt.done = 1'b1;
					st_nxt.state = ST_IDLE;
				end
			end
			ST_POLL_A: begin
				if (bus_done) begin
					st_nxt.wait_bus = 1'b0;
					st_nxt.tog_first = bus_rdata[BIT_TOGGLE];
					st_nxt.state = ST_POLL_B;
				end
			end
			ST_POLL_B: begin
				if (bus_done) begin
					st_nxt.wait_bus = 1'b0;
					st_nxt.rdata = bus_rdata;
					if (bus_rdata[BIT_TOGGLE] == st_r.tog_first) begin
						// steady toggle bit; a program must also show its top bits
						if (st_r.op == OP_PROGRAM) begin
							st_nxt.fail = bus_rdata[BIT_POLL:BIT_TOGGLE] != st_r.data[BIT_POLL:BIT_TOGGLE];
						end
						st_nxt.win_open = 1'b0;
						st_nxt.done = 1'b1;
						st_nxt.state = ST_IDLE;
					end else if (st_r.tmo_seen) begin
						// still toggling after timeout: failed, reset the device
						st_nxt.op = OP_RESET;
						st_nxt.idx = '0;
						st_nxt.fail = 1'b1;
						st_nxt.state = ST_WRITE;
					end else begin
						st_nxt.tmo_seen = bus_rdata[BIT_TIMEOUT];
						st_nxt.state = ST_POLL_A;
					end
				end
			end
			default: begin
				st_nxt.state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			st_r <= '{state: ST_IDLE, op: OP_READ, idx: '0, addr: '0, data: '0, wait_bus: 1'b0,
				tog_first: 1'b0, tmo_seen: 1'b0, fail: 1'b0, done: 1'b0, rdata: '0, win_cnt: '0, win_open: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	ffc_bus_cycle #(
		.AW(AW),
		.DW(DW)
	) u_bus (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_start(bus_start),
		.i_write(bus_write),
		.i_addr(bus_addr),
		.i_wdata(bus_wdata),
		.o_done(bus_done),
		.o_rdata(bus_rdata),
		.o_ce_n(o_flash_ce_n),
		.o_oe_n(o_flash_oe_n),
		.o_we_n(o_flash_we_n),
		.o_addr(o_flash_addr),
		.o_dq_o(o_flash_dq_o),
		.o_dq_oe(o_flash_dq_oe),
		.i_dq_i(i_flash_dq_i)
	);

	assign o_cmd_ready = st_r.state == ST_IDLE;
	assign o_done = st_r.done;
	assign o_fail = st_r.fail;
	assign o_rdata = st_r.rdata;
	assign o_erase_window_open = st_r.win_open;

endmodule // ffc_ctrl

// >>> verification/ffc_ctrl_sva.sv
// ffc_ctrl_sva: port-level checks of the flash command controller.
// assumes it is bound onto ffc_ctrl and sees only its ports.
`timescale 1ns/1ps

module ffc_ctrl_sva import ffc_pkg::*; #(
	parameter int AW = ADDR_W
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_cmd_valid,
	input wire logic o_cmd_ready,
	input wire logic o_done,
	input wire logic o_erase_window_open,
	input wire logic o_flash_ce_n,
	input wire logic o_flash_oe_n,
	input wire logic o_flash_we_n,
	input wire logic [AW-1:0] o_flash_addr,
	input wire logic o_flash_dq_oe
);
	// cycles since the write strobe was last low
	int win_cnt_r;

	always_ff @(posedge i_clock) begin
		if (i_rst || !o_flash_we_n)
			win_cnt_r <= 0;
		else if (win_cnt_r < 4000)
			win_cnt_r <= win_cnt_r + 1;
	end

	default clocking dcb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	////////////////////////////////////////////////////////////////////////////////
	bus_clash_a: assert property (!(!o_flash_oe_n && !o_flash_we_n))
		else $error("read and write strobes low together");
	write_gate_a: assert property (!o_flash_we_n |-> !o_flash_ce_n && o_flash_oe_n && o_flash_dq_oe)
		else $error("write strobe without select or data drive");
	read_gate_a: assert property (!o_flash_oe_n |-> !o_flash_ce_n && !o_flash_dq_oe)
		else $error("read strobe while driving data");
	strobe_width_a: assert property ($fell(o_flash_we_n) |-> !o_flash_we_n [*3] ##1 o_flash_we_n)
		else $error("write strobe width wrong");
	write_addr_a: assert property (!o_flash_we_n |-> $stable(o_flash_addr))
		else $error("address moved during write strobe");
	take_busy_a: assert property (i_cmd_valid && o_cmd_ready |=> !o_cmd_ready)
		else $error("ready stayed high after a command was taken");
	done_pulse_a: assert property (o_done |-> o_cmd_ready ##1 !o_done)
		else $error("done not a single pulse in idle");
	idle_quiet_a: assert property (o_cmd_ready |-> o_flash_ce_n && !o_flash_dq_oe)
		else $error("flash selected while idle");
	window_len_a: assert property (o_erase_window_open |-> win_cnt_r <= 1503)
		else $error("erase window open too long");
endmodule // ffc_ctrl_sva

bind ffc_ctrl ffc_ctrl_sva #(.AW(AW)) u_sva (
	.i_clock(i_clock),
	.i_rst(i_rst),
	.i_cmd_valid(i_cmd_valid),
	.o_cmd_ready(o_cmd_ready),
	.o_done(o_done),
	.o_erase_window_open(o_erase_window_open),
	.o_flash_ce_n(o_flash_ce_n),
	.o_flash_oe_n(o_flash_oe_n),
	.o_flash_we_n(o_flash_we_n),
	.o_flash_addr(o_flash_addr),
	.o_flash_dq_oe(o_flash_dq_oe)
);

// >>> verification/ffc_flash_model.sv
// ffc_flash_model: behavioural byte-wide flash driven by strobe edges.
// assumes package unlock/reset defaults; sector PROT_SECTOR protected.
`timescale 1ns/1ps

module ffc_flash_model import ffc_pkg::*; #(
	parameter logic [3:0] PROT_SECTOR = 4'hF,
	parameter logic [7:0] ID_CODE = 8'h5C, // arbitrary value
	parameter int PGM_READS = 4,
	parameter int STUCK_READS = 6,
	parameter int ERASE_READS = 12
) (
	input wire logic i_ce_n,
	input wire logic i_oe_n,
	input wire logic i_we_n,
	input wire logic [17:0] i_addr,
	input wire logic [7:0] i_dq,
	output logic [7:0] o_dq
);
	logic [7:0] mem [int];
	logic [7:0] pdata;
	logic [7:0] dout = 8'h00;
	logic [17:0] paddr;
	logic [17:0] wa;
	logic [15:0] sel = 16'h0000;
	logic pgm_arm, id_mode, busy, stuck, timeout, erasing, prot_busy;
	logic tog = 1'b0;
	logic tog2 = 1'b0;
	int step;
	int reads;
	realtime t_last, t_prot;

	function automatic logic [7:0] arr(logic [17:0] a);
		return mem.exists(a) ? mem[a] : 8'hFF;
	endfunction

	function automatic bit started();
		return erasing && ($realtime - t_last > 30000.0);
	endfunction

	task automatic clear();
		step = 0;
		pgm_arm = 1'b0;
		id_mode = 1'b0;
		busy = 1'b0;
		timeout = 1'b0;
		erasing = 1'b0;
		prot_busy = 1'b0;
	endtask

	task automatic wr(logic [17:0] a, logic [7:0] d);
		bit rst_cmd;
		bit u1;
		bit u2;
		rst_cmd = a == DEF_RESET_ADDR && d == DEF_RESET_DATA;
		u1 = a == DEF_UNLOCK1_ADDR && d == DEF_UNLOCK1_DATA;
		u2 = a == DEF_UNLOCK2_ADDR && d == DEF_UNLOCK2_DATA;
		if (started())
			return;
		if (rst_cmd || busy) begin
			if (rst_cmd)
				clear();
			return;
		end
		if (erasing) begin
			if (d == CMD_SECTOR_ERASE) begin
				sel[a[17:14]] = 1'b1;
				t_last = $realtime;
			end else
				erasing = 1'b0;
			return;
		end
		if (pgm_arm) begin
			pgm_arm = 1'b0;
			paddr = a;
			pdata = d;
			reads = 0;
			t_prot = $realtime;
			prot_busy = a[17:14] == PROT_SECTOR;
			busy = !prot_busy;
			stuck = (arr(a) & d) != d;
			return;
		end
		case (step)
			0: step = u1 ? 1 : 0;
			1: step = u2 ? 2 : 0;
			2: begin
				step = (a == DEF_UNLOCK1_ADDR && d == CMD_ERASE_SETUP) ? 3 : 0;
				pgm_arm = a == DEF_UNLOCK1_ADDR && d == CMD_PROGRAM;
				id_mode = a == DEF_UNLOCK1_ADDR && d == DEF_ID_DATA;
			end
			3: step = u1 ? 4 : 0;
			4: step = u2 ? 5 : 0;
			default: begin
				step = 0;
				erasing = d == CMD_SECTOR_ERASE;
				sel = 16'h0000;
				sel[a[17:14]] = 1'b1;
				t_last = $realtime;
				reads = 0;
			end
		endcase
	endtask

	task automatic erase_done();
		int q[$];
		foreach (mem[k])
			if (sel[k[17:14]] && k[17:14] != PROT_SECTOR)
				q.push_back(k);
		foreach (q[i])
			mem.delete(q[i]);
		erasing = 1'b0;
	endtask

	initial
		clear();

	always @(negedge i_we_n)
		if (!i_ce_n && i_oe_n)
			wa = i_addr;
	always @(posedge i_we_n)
		if (!i_ce_n && i_oe_n)
			wr(wa, i_dq);

	always @(negedge i_oe_n) begin
		if (!i_ce_n) begin
			tog = ~tog;
			if (busy) begin
				reads++;
				timeout = timeout || (stuck && reads > STUCK_READS);
				dout = {~pdata[7], tog, timeout, 5'h00};
				if (!stuck && reads >= PGM_READS) begin
					mem[paddr] = pdata;
					busy = 1'b0;
				end
			end else if (prot_busy && $realtime - t_prot < 2000.0)
				dout = arr(i_addr) ^ {1'b0, tog, 6'h00};
			else if (erasing) begin
				if (started())
					reads++;
				tog2 = tog2 ^ sel[i_addr[17:14]];
				dout = {1'b0, tog, 2'b00, started(), tog2 & sel[i_addr[17:14]], 2'b00};
				if (reads > ERASE_READS) begin
					erase_done();
					dout = arr(i_addr);
				end
			end else if (id_mode)
				dout = i_addr[1] ? {7'h00, i_addr[17:14] == PROT_SECTOR} : ID_CODE;
			else
				dout = arr(i_addr);
		end
	end

	// released bus shows the inverse of the last byte
	assign o_dq = (!i_ce_n && !i_oe_n) ? dout : ~dout;
endmodule // ffc_flash_model

// >>> verification/ffc_ctrl_tb.sv
// ffc_ctrl_tb: self-checking bench for the flash command controller.
// assumes ffc_flash_model on the flash pins and the checker bound to ffc_ctrl.
`timescale 1ns/1ps

module ffc_ctrl_tb import ffc_pkg::*; ;
	logic i_clock = 1'b0;
	logic i_rst = 1'b1;
	logic i_cmd_valid = 1'b0;
	ffc_op_t i_cmd_op = OP_READ;
	logic [17:0] i_cmd_addr = 18'h00000;
	logic [7:0] i_cmd_data = 8'h00;
	logic o_cmd_ready, o_done, o_fail, o_erase_window_open, ce_n, oe_n, we_n, dq_oe;
	logic [7:0] o_rdata, dq_o, mdl_q, bus;
	logic [17:0] fa;
	int fails = 0;
	int compares = 0;

	always #10 i_clock = ~i_clock;
	assign bus = dq_oe ? dq_o : mdl_q;

	ffc_ctrl DUT (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_cmd_valid(i_cmd_valid),
		.i_cmd_op(i_cmd_op),
		.i_cmd_addr(i_cmd_addr),
		.i_cmd_data(i_cmd_data),
		.o_cmd_ready(o_cmd_ready),
		.o_done(o_done),
		.o_fail(o_fail),
		.o_rdata(o_rdata),
		.o_erase_window_open(o_erase_window_open),
		.o_flash_ce_n(ce_n),
		.o_flash_oe_n(oe_n),
		.o_flash_we_n(we_n),
		.o_flash_addr(fa),
		.o_flash_dq_o(dq_o),
		.o_flash_dq_oe(dq_oe),
		.i_flash_dq_i(bus)
	);

	ffc_flash_model u_flash (
		.i_ce_n(ce_n),
		.i_oe_n(oe_n),
		.i_we_n(we_n),
		.i_addr(fa),
		.i_dq(bus),
		.o_dq(mdl_q)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(string what, logic [7:0] exp, logic [7:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one command, then wait for done and compare the fail flag
	task automatic cmd(ffc_op_t op, logic [17:0] a, logic [7:0] d, logic exp_fail);
		int n;
		@(negedge i_clock);
		i_cmd_op = op;
		i_cmd_addr = a;
		i_cmd_data = d;
		i_cmd_valid = 1'b1;
		@(negedge i_clock);
		i_cmd_valid = 1'b0;
		n = 0;
		while (o_done !== 1'b1 && n < 20000) begin
			@(negedge i_clock);
			n++;
		end
		check("done seen", 8'h01, {7'h00, o_done});
		check("fail flag", {7'h00, exp_fail}, {7'h00, o_fail});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(negedge i_clock);
		i_rst = 1'b0;
		check("ready", 8'h01, {7'h00, o_cmd_ready});
		check("idle strobes", 8'h07, {5'h00, ce_n, oe_n, we_n});
		cmd(OP_PROGRAM, 18'h00100, 8'h5A, 1'b0);
		cmd(OP_PROGRAM, 18'h04010, 8'h33, 1'b0);
		cmd(OP_READ, 18'h00100, 8'h00, 1'b0);
		check("array byte", 8'h5A, o_rdata);
		cmd(OP_PROGRAM, 18'h00100, 8'hA5, 1'b1);
		cmd(OP_READ, 18'h00100, 8'h00, 1'b0);
		check("byte after timeout", 8'h5A, o_rdata);
		cmd(OP_PROGRAM, 18'h3C000, 8'h00, 1'b1);
		cmd(OP_READ, 18'h3C000, 8'h00, 1'b0);
		check("protected byte", 8'hFF, o_rdata);
		cmd(OP_ERASE, 18'h00000, 8'h00, 1'b0);
		check("window open", 8'h01, {7'h00, o_erase_window_open});
		cmd(OP_ADD_SECTOR, 18'h04000, 8'h00, 1'b0);
		// status after the load: polling bit low, timer low, secondary toggle set in the chosen sector
		check("erase status", 8'h04, o_rdata & 8'h8C);
		cmd(OP_POLL, 18'h00100, 8'h00, 1'b0);
		check("erased byte", 8'hFF, o_rdata);
		cmd(OP_READ, 18'h04010, 8'h00, 1'b0);
		check("added sector byte", 8'hFF, o_rdata);
		cmd(OP_ERASE, 18'h00000, 8'h00, 1'b0);
		repeat (1600) @(negedge i_clock);
		check("window shut", 8'h00, {7'h00, o_erase_window_open});
		cmd(OP_ADD_SECTOR, 18'h04000, 8'h00, 1'b1);
		cmd(OP_POLL, 18'h00000, 8'h00, 1'b0);
		// third pass reads the partner's arbitrary identifier code
		for (int i = 0; i < 3; i++) begin
			cmd(OP_ID, i == 2 ? 18'h00000 : i == 1 ? 18'h3C002 : 18'h00002, 8'h00, 1'b0);
			check("id byte", i == 2 ? 8'h5C : i == 1 ? 8'h01 : 8'h00, o_rdata);
			cmd(OP_RESET, 18'h00000, 8'h00, 1'b0);
		end
		cmd(OP_READ, 18'h00100, 8'h00, 1'b0);
		check("array after id", 8'hFF, o_rdata);
		close_out();
	end

	initial begin
		repeat (90000) @(posedge i_clock);
		fails++;
		$display("CHECK FAILED watchdog expected end seen hang");
		close_out();
	end
endmodule // ffc_ctrl_tb
